// >>> rtl/tcd_decoder.sv
// Purpose: Receive-side control character and escape interpreter
// Assumes: Host stream on rx ports, display sink on disp ports
// Notes:   Cursor is zero based; no auto wrap on printable text
// Notes on behaviour
// - BEL pulses bell, nothing else changes
// - BS moves left, stops at margin
// - HT to next eighth column, clamp right
// - LF moves down; newline mode also returns
// - FF clears screen, cursor home
// - CR returns to left margin, row kept
// - SO selects G1, SI selects G0
// - XON clears transmit suspend
// - XOFF suspends; only XON/XOFF then sent
// - CAN/SUB abort sequence, show error glyph
// - ESC starts escape sequence collection
// - Unsupported controls are silently ignored
// - ESC ( or ) plus final designates slot
// - Any set allowed in either slot
// - Reset loads strap default into both slots
// - Sequence characters compared case-sensitively
// - Space never forms part of sequence
module tcd_decoder #(
   parameter int COLS  = tcd_pkg::NUM_COLS,
   parameter int ROWS  = tcd_pkg::NUM_ROWS,
   parameter int DEPTH = tcd_pkg::FIFO_DEPTH
) (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic [7:0] rxData,
   input  wire logic       rxValid,
   output logic            rxReady,
   input  wire logic       newLineMode,
   input  wire logic [2:0] defaultCharset,
   output logic [7:0]      dispChar,
   output logic [2:0]      dispCharset,
   output logic            dispValid,
   input  wire logic       dispReady,
   output logic [6:0]      cursorCol,
   output logic [4:0]      cursorRow,
   output logic            bellPulse,
   output logic            clearPulse,
   output logic [2:0]      activeCharset,
   output logic            txSuspended,
   input  wire logic [7:0] kbdData,
   input  wire logic       kbdValid,
   output logic            kbdReady,
   output logic [7:0]      txData,
   output logic            txValid,
   input  wire logic       txReady
);
   localparam logic [6:0] LAST_COL = 7'(COLS - 1);
   localparam logic [4:0] LAST_ROW = 5'(ROWS - 1);

   // Received characters travel from the FIFO over this stream
   tcd_stream_if #(.WIDTH(8)) rxIf ();

   // Parser state
   tcd_pkg::tcd_state_e state;
   tcd_pkg::tcd_state_e next_state;

   // Cursor, slots and flow control
   logic [6:0] next_cursorCol;
   logic [4:0] next_cursorRow;
   logic [2:0] g0Set;
   logic [2:0] g1Set;
   logic [2:0] next_g0Set;
   logic [2:0] next_g1Set;
   logic       shiftOut;
   logic       next_shiftOut;
   logic [2:0] next_activeCharset;
   logic       next_txSuspended;

   // Display stage and pulses
   logic [7:0] next_dispChar;
   logic [2:0] next_dispCharset;
   logic       next_dispValid;
   logic       next_bellPulse;
   logic       next_clearPulse;

   // Strap synchronisers and start-up load
   logic       nlSync1;
   logic       nlSync2;
   logic [2:0] csSync1;
   logic [2:0] csSync2;
   logic [2:0] strapSet;
   logic [1:0] initCnt;
   logic [1:0] next_initCnt;
   logic       loaded;
   logic       next_loaded;

   // Per-character decode helpers
   logic       take;
   logic [7:0] ch;
   logic       showGlyph;
   logic [7:0] glyph;
   logic [3:0] finSet;

   // Next fixed tab stop, clamped at the right margin
   function automatic logic [6:0] tabStop(input logic [6:0] col);
      int stop;
      stop = (int'(col) / tcd_pkg::TAB_STEP + 1) * tcd_pkg::TAB_STEP;
      if (stop > int'(LAST_COL))
         stop = int'(LAST_COL);
      return 7'(stop);
   endfunction

   // Designation final to set code, bit 3 marks a known final
   function automatic logic [3:0] finalToSet(input logic [7:0] fin);
      case (fin)
         tcd_pkg::FIN_UK: return {1'b1, tcd_pkg::CS_UK};
         tcd_pkg::FIN_US: return {1'b1, tcd_pkg::CS_US};
         tcd_pkg::FIN_S1: return {1'b1, tcd_pkg::CS_SOFT1};
         tcd_pkg::FIN_S2: return {1'b1, tcd_pkg::CS_SOFT2};
         tcd_pkg::FIN_S3: return {1'b1, tcd_pkg::CS_SOFT3};
         default:         return 4'h0;
      endcase
   endfunction

   // True for a character that ends an escape sequence
   function automatic logic isFinal(input logic [7:0] c);
      return (c >= tcd_pkg::FIN_LO) && (c <= tcd_pkg::FIN_HI);
   endfunction

   // Host character buffer
   tcd_fifo #(
      .WIDTH (8),
      .DEPTH (DEPTH)
   ) i_tcd_fifo (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .inData  (rxData),
      .inValid (rxValid),
      .inReady (rxReady),
      .outPort (rxIf)
   );

   // Keyboard to host path; fed the next suspend so it hides in step
   tcd_tx_gate i_tcd_tx_gate (
      .clk_sys  (clk_sys),
      .nrst     (nrst),
      .suspend  (next_txSuspended),
      .inData   (kbdData),
      .inValid  (kbdValid),
      .inReady  (kbdReady),
      .outData  (txData),
      .outValid (txValid),
      .outReady (txReady)
   );

   // Take a character only when the display stage can hold a glyph
   assign rxIf.ready = loaded && (!dispValid || dispReady);

   // Strap pins cross into the clock domain through two flops
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         nlSync1 <= 1'b0;
         nlSync2 <= 1'b0;
         csSync1 <= tcd_pkg::CS_UK;
         csSync2 <= tcd_pkg::CS_UK;
      end
      else
      begin
         nlSync1 <= newLineMode;
         nlSync2 <= nlSync1;
         csSync1 <= defaultCharset;
         csSync2 <= csSync1;
      end
   end

   // Character interpreter: controls, sequences and text
   always_comb
   begin
      ch               = rxIf.data;
      take             = rxIf.valid && rxIf.ready;
      next_state       = state;
      next_cursorCol   = cursorCol;
      next_cursorRow   = cursorRow;
      next_g0Set       = g0Set;
      next_g1Set       = g1Set;
      next_shiftOut    = shiftOut;
      next_txSuspended = txSuspended;
      next_bellPulse   = 1'b0;
      next_clearPulse  = 1'b0;
      next_dispValid   = dispValid && !dispReady;
      next_dispChar    = dispChar;
      next_dispCharset = dispCharset;
      next_initCnt     = initCnt;
      next_loaded      = loaded;
      showGlyph        = 1'b0;
      glyph            = ch;
      finSet           = finalToSet(ch);
      strapSet         = (csSync2 > tcd_pkg::CS_SOFT3) ? tcd_pkg::CS_UK : csSync2;
      if (take && ch < tcd_pkg::CH_SPACE)
      begin
         // Controls act in every parser state
         case (ch)
            tcd_pkg::CH_BEL:
               next_bellPulse = 1'b1;
            tcd_pkg::CH_BS:
               if (cursorCol != 7'h00)
                  next_cursorCol = cursorCol - 7'h01;
            tcd_pkg::CH_HT:
               next_cursorCol = tabStop(cursorCol);
            tcd_pkg::CH_LF:
            begin
               if (cursorRow != LAST_ROW)
                  next_cursorRow = cursorRow + 5'h01;
               if (nlSync2)
                  next_cursorCol = 7'h00;
            end
            tcd_pkg::CH_FF:
            begin
               next_clearPulse = 1'b1;
               next_cursorCol  = 7'h00;
               next_cursorRow  = 5'h00;
            end
            tcd_pkg::CH_CR:
               next_cursorCol = 7'h00;
            tcd_pkg::CH_SO:
               next_shiftOut = 1'b1;
            tcd_pkg::CH_SI:
               next_shiftOut = 1'b0;
            tcd_pkg::CH_XON:
               next_txSuspended = 1'b0;
            tcd_pkg::CH_XOFF:
               next_txSuspended = 1'b1;
            tcd_pkg::CH_CAN,
            tcd_pkg::CH_SUB:
               if (state != tcd_pkg::ST_TEXT)
               begin
                  next_state = tcd_pkg::ST_TEXT;
                  showGlyph  = 1'b1;
                  glyph      = tcd_pkg::CH_ERROR;
               end
            tcd_pkg::CH_ESC:
               next_state = tcd_pkg::ST_ESC;
            default:
               next_state = state;
         endcase
      end
      else if (take && ch == tcd_pkg::CH_SPACE)
      begin
         // Space ends any sequence and is shown as text
         next_state = tcd_pkg::ST_TEXT;
         showGlyph  = 1'b1;
      end
      else if (take && ch < tcd_pkg::CH_DEL)
      begin
         case (state)
            tcd_pkg::ST_TEXT:
               showGlyph = 1'b1;
            tcd_pkg::ST_ESC:
               if (ch == tcd_pkg::SQ_G0)
                  next_state = tcd_pkg::ST_DESIG0;
               else if (ch == tcd_pkg::SQ_G1)
                  next_state = tcd_pkg::ST_DESIG1;
               else if (ch == tcd_pkg::SQ_CSI)
                  next_state = tcd_pkg::ST_CSI;
               else if (isFinal(ch))
                  next_state = tcd_pkg::ST_TEXT;
               else
                  next_state = tcd_pkg::ST_SKIP;
            tcd_pkg::ST_DESIG0:
            begin
               if (finSet[3])
                  next_g0Set = finSet[2:0];
               next_state = tcd_pkg::ST_TEXT;
            end
            tcd_pkg::ST_DESIG1:
            begin
               if (finSet[3])
                  next_g1Set = finSet[2:0];
               next_state = tcd_pkg::ST_TEXT;
            end
            tcd_pkg::ST_CSI:
               if (ch >= tcd_pkg::CSI_LO)
                  next_state = tcd_pkg::ST_TEXT;
            tcd_pkg::ST_SKIP:
               if (isFinal(ch))
                  next_state = tcd_pkg::ST_TEXT;
            default:
               next_state = tcd_pkg::ST_TEXT;
         endcase
      end
      // Shown glyphs advance the cursor, no wrap at the margin
      if (showGlyph)
      begin
         next_dispValid   = 1'b1;
         next_dispChar    = glyph;
         next_dispCharset = activeCharset;
         if (cursorCol != LAST_COL)
            next_cursorCol = cursorCol + 7'h01;
      end
      // Both slots take the strap set once it has settled
      if (!loaded)
      begin
         if (initCnt == tcd_pkg::INIT_CYCLES)
         begin
            next_loaded = 1'b1;
            next_g0Set  = strapSet;
            next_g1Set  = strapSet;
         end
         else
            next_initCnt = initCnt + 2'h1;
      end
      next_activeCharset = next_shiftOut ? next_g1Set : next_g0Set;
   end

   // Interpreter registers
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         state         <= tcd_pkg::ST_TEXT;
         cursorCol     <= 7'h00;
         cursorRow     <= 5'h00;
         g0Set         <= tcd_pkg::CS_UK;
         g1Set         <= tcd_pkg::CS_UK;
         shiftOut      <= 1'b0;
         activeCharset <= tcd_pkg::CS_UK;
         txSuspended   <= 1'b0;
         bellPulse     <= 1'b0;
         clearPulse    <= 1'b0;
         dispValid     <= 1'b0;
         dispChar      <= 8'h00;
         dispCharset   <= tcd_pkg::CS_UK;
         initCnt       <= 2'h0;
         loaded        <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         cursorCol     <= next_cursorCol;
         cursorRow     <= next_cursorRow;
         g0Set         <= next_g0Set;
         g1Set         <= next_g1Set;
         shiftOut      <= next_shiftOut;
         activeCharset <= next_activeCharset;
         txSuspended   <= next_txSuspended;
         bellPulse     <= next_bellPulse;
         clearPulse    <= next_clearPulse;
         dispValid     <= next_dispValid;
         dispChar      <= next_dispChar;
         dispCharset   <= next_dispCharset;
         initCnt       <= next_initCnt;
         loaded        <= next_loaded;
      end
   end
endmodule // tcd_decoder

// >>> rtl/tcd_fifo.sv
// Purpose: Receive character FIFO with registered output stage
// Assumes: Single clock, push and pop may coincide
// Notes:   inReady is registered and reflects free storage
module tcd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   tcd_stream_if.src             outPort
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr, rdPtr, next_wrPtr, next_rdPtr;
   logic [AW:0]      memCnt, next_memCnt;
   logic [WIDTH-1:0] outData;
   logic             outValid, next_outValid, next_inReady;
   logic             push, pop;

   assign outPort.data  = outData;
   assign outPort.valid = outValid;

   // Pointer, count and ready computation
   always_comb
   begin
      push          = inValid && inReady;
      pop           = (memCnt != '0) && (!outValid || outPort.ready);
      next_wrPtr    = push ? wrPtr + 1'b1 : wrPtr;
      next_rdPtr    = pop ? rdPtr + 1'b1 : rdPtr;
      next_memCnt   = memCnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      next_outValid = pop || (outValid && !outPort.ready);
      next_inReady  = next_memCnt < (AW+1)'(DEPTH);
   end

   // Control registers
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         wrPtr    <= '0;
         rdPtr    <= '0;
         memCnt   <= '0;
         outValid <= 1'b0;
         inReady  <= 1'b0;
      end
      else
      begin
         wrPtr    <= next_wrPtr;
         rdPtr    <= next_rdPtr;
         memCnt   <= next_memCnt;
         outValid <= next_outValid;
         inReady  <= next_inReady;
      end
   end

   // Storage and registered read data
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem[wrPtr] <= inData;
      if (pop)
         outData <= mem[rdPtr];
   end
endmodule // tcd_fifo

// >>> rtl/tcd_pkg.sv
// Purpose: Shared constants for the terminal control character decoder
// Assumes: 8-bit received characters, one system clock
// Notes:   Charset codes are internal encodings of the five sets
package tcd_pkg;
   // Control character codes
   localparam logic [7:0] CH_BEL   = 8'h07;
   localparam logic [7:0] CH_BS    = 8'h08;
   localparam logic [7:0] CH_HT    = 8'h09;
   localparam logic [7:0] CH_LF    = 8'h0A;
   localparam logic [7:0] CH_FF    = 8'h0C;
   localparam logic [7:0] CH_CR    = 8'h0D;
   localparam logic [7:0] CH_SO    = 8'h0E;
   localparam logic [7:0] CH_SI    = 8'h0F;
   localparam logic [7:0] CH_XON   = 8'h11;
   localparam logic [7:0] CH_XOFF  = 8'h13;
   localparam logic [7:0] CH_CAN   = 8'h18;
   localparam logic [7:0] CH_SUB   = 8'h1A;
   localparam logic [7:0] CH_ESC   = 8'h1B;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_DEL   = 8'h7F;
   // Sequence characters
   localparam logic [7:0] SQ_G0    = 8'h28;
   localparam logic [7:0] SQ_G1    = 8'h29;
   localparam logic [7:0] SQ_CSI   = 8'h5B;
   localparam logic [7:0] FIN_UK   = 8'h41;
   localparam logic [7:0] FIN_US   = 8'h42;
   localparam logic [7:0] FIN_S1   = 8'h30;
   localparam logic [7:0] FIN_S2   = 8'h31;
   localparam logic [7:0] FIN_S3   = 8'h32;
   localparam logic [7:0] FIN_LO   = 8'h30;
   localparam logic [7:0] CSI_LO   = 8'h40;
   localparam logic [7:0] FIN_HI   = 8'h7E;
   // Glyph shown when a sequence is aborted
   localparam logic [7:0] CH_ERROR = 8'h3F;
   // Character set encodings
   localparam logic [2:0] CS_UK    = 3'h0;
   localparam logic [2:0] CS_US    = 3'h1;
   localparam logic [2:0] CS_SOFT1 = 3'h2;
   localparam logic [2:0] CS_SOFT2 = 3'h3;
   localparam logic [2:0] CS_SOFT3 = 3'h4;
   // Cycles after reset before the synchronised strap is trusted
   localparam logic [1:0] INIT_CYCLES = 2'h3;
   // Default screen geometry, tab step and receive FIFO depth
   localparam int NUM_COLS = 80;
   localparam int NUM_ROWS = 24;
   localparam int TAB_STEP = 8;
   localparam int FIFO_DEPTH = 16;
   // Parser states
   typedef enum logic [2:0] {
      ST_TEXT,
      ST_ESC,
      ST_DESIG0,
      ST_DESIG1,
      ST_CSI,
      ST_SKIP
   } tcd_state_e;
endpackage

// >>> rtl/tcd_stream_if.sv
// Purpose: Valid/ready character stream between internal modules
// Assumes: Source and sink on the same clock
// Notes:   Word is taken when valid and ready are both high
interface tcd_stream_if #(parameter int WIDTH = 8);
   logic [WIDTH-1:0] data;
   logic             valid;
   logic             ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// >>> rtl/tcd_tx_gate.sv
// Purpose: Transmit path gate obeying host flow control
// Assumes: suspend comes from logic on the same clock
// Notes:   While suspended only XON and XOFF pass, others wait
module tcd_tx_gate (
   input  wire logic       clk_sys,
   input  wire logic       nrst,
   input  wire logic       suspend,
   input  wire logic [7:0] inData,
   input  wire logic       inValid,
   output logic            inReady,
   output logic [7:0]      outData,
   output logic            outValid,
   input  wire logic       outReady
);
   logic       allowed, take, held, next_held, next_outValid;
   logic [7:0] next_outData;

   // Flow characters may pass a suspended link
   function automatic logic isFlow(input logic [7:0] c);
      return c == tcd_pkg::CH_XON || c == tcd_pkg::CH_XOFF;
   endfunction

   // Accept one character when the stage is empty; hide it while suspended
   always_comb
   begin
      allowed       = !suspend || isFlow(inData);
      take          = inValid && inReady && allowed;
      next_held     = take || (held && !(outValid && outReady));
      next_outData  = take ? inData : outData;
      next_outValid = next_held && (!suspend || isFlow(next_outData));
   end

   // Output stage registers
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         held     <= 1'b0;
         outValid <= 1'b0;
         outData  <= 8'h00;
         inReady  <= 1'b0;
      end
      else
      begin
         held     <= next_held;
         outValid <= next_outValid;
         outData  <= next_outData;
         inReady  <= !next_held;
      end
   end
endmodule // tcd_tx_gate

// >>> verif/tcd_decoder_props.sv
// Purpose: Port checks on the decoder
// Assumes: Bound to tcd_decoder
// Notes:   Cursor, charset and flow relations only
module tcd_decoder_props #(
   parameter int COLS = 80,
   parameter int ROWS = 24
) (
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic [6:0] cursorCol,
   input wire logic [4:0] cursorRow,
   input wire logic       bellPulse,
   input wire logic       clearPulse,
   input wire logic [2:0] activeCharset,
   input wire logic       txSuspended,
   input wire logic [7:0] txData,
   input wire logic       txValid,
   input wire logic       txReady
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Cursor motion and bounds, charset range and transmit flow
   property p_bel; bellPulse |-> $stable(cursorCol) && $stable(cursorRow); endproperty
   a_bel: assert property (p_bel) else $error("bell moved cursor");
   property p_left; cursorCol < $past(cursorCol) |-> cursorCol == 7'h00 ||
      cursorCol == $past(cursorCol) - 7'h01; endproperty
   a_left: assert property (p_left) else $error("bad left move");
   property p_tab; cursorCol > $past(cursorCol) + 7'h01 |-> cursorCol[2:0] == 3'h0 ||
      cursorCol == COLS - 1; endproperty
   a_tab: assert property (p_tab) else $error("bad tab stop");
   property p_colMax; cursorCol < COLS; endproperty
   a_colMax: assert property (p_colMax) else $error("column past margin");
   property p_row; cursorRow != $past(cursorRow) |-> cursorRow == 5'h00 ||
      cursorRow == $past(cursorRow) + 5'h01; endproperty
   a_row: assert property (p_row) else $error("bad row move");
   property p_rowMax; cursorRow < ROWS; endproperty
   a_rowMax: assert property (p_rowMax) else $error("row past margin");
   property p_clr; clearPulse |-> ##[0:2] cursorCol == 7'h00 && cursorRow == 5'h00; endproperty
   a_clr: assert property (p_clr) else $error("clear without home");
   property p_cs; activeCharset <= tcd_pkg::CS_SOFT3; endproperty
   a_cs: assert property (p_cs) else $error("illegal set");
   property p_tx; txSuspended && txValid && txReady |-> txData == tcd_pkg::CH_XON ||
      txData == tcd_pkg::CH_XOFF; endproperty
   a_tx: assert property (p_tx) else $error("sent while suspended");
   // Main scenarios
   c_bel: cover property (bellPulse);
   c_clr: cover property (clearPulse);
   c_sus: cover property (txSuspended && txValid);
endmodule // tcd_decoder_props
bind tcd_decoder tcd_decoder_props #(.COLS(COLS), .ROWS(ROWS)) i_tcd_decoder_props (.*);

// >>> verif/tcd_decoder_tb.sv
// Purpose: Directed checks of the decoder
// Assumes: Sinks stall on a fixed pattern
// Notes:   Strings pushed back to back
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin nMismatch++; \
   $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tcd_decoder_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 0, nrst = 0, rxValid = 0, newLineMode = 0, kbdValid = 0;
   logic [7:0] rxData = 8'h00, kbdData = 8'h61, dispChar, txData, lastChar;
   logic [2:0] defaultCharset = tcd_pkg::CS_US, dispCharset, activeCharset;
   logic dispValid, dispReady, rxReady, bellPulse, clearPulse, txSuspended, kbdReady;
   logic txValid, txReady;
   logic [6:0] cursorCol;
   logic [4:0] cursorRow;
   int nMismatch = 0, checkCount = 0, nBell = 0, nClr = 0;
   tcd_decoder i_tcd_decoder (.*);
   tcd_host_sink i_tcd_host_sink (.*);
   always #2 clk_sys = ~clk_sys;
   // Pulse counters
   always @(posedge clk_sys)
   begin
      nBell += (bellPulse === 1'b1);
      nClr += (clearPulse === 1'b1);
   end
   task automatic push(input string s);
      int i;
      for (int k = 0; k < s.len(); k++)
      begin
         rxData <= s[k];
         rxValid <= 1'b1;
         i = 0;
         do begin @(posedge clk_sys); i++; end while (rxReady !== 1'b1 && i < 100);
      end
      rxValid <= 1'b0;
      repeat (40) @(posedge clk_sys);
   endtask
   task automatic t_cursor;
      push("\015\011\011\010\007");
      `CHK("col", 7'h0F, cursorCol)
      `CHK("bell", 1, nBell)
      push("\012");
      `CHK("row", 5'h01, cursorRow)
      newLineMode <= 1'b1;
      push("\012\010\001");
      `CHK("row", 5'h02, cursorRow)
      `CHK("col", 7'h00, cursorCol)
      push("\014");
      `CHK("row", 5'h00, cursorRow)
      `CHK("clear", 1, nClr)
      $display("t_cursor done");
   endtask
   task automatic t_charset;
      push("\016");
      `CHK("set", tcd_pkg::CS_US, activeCharset)
      push("\033(2\033)0\016");
      `CHK("set", tcd_pkg::CS_SOFT1, activeCharset)
      push("\017\033)a\033) B\016");
      `CHK("set", tcd_pkg::CS_SOFT1, activeCharset)
      push("\033)2\016");
      `CHK("set", tcd_pkg::CS_SOFT3, activeCharset)
      push("\033(A\017");
      `CHK("set", tcd_pkg::CS_UK, activeCharset)
      push("\033(1\033\030\033(\032B\033\032\017");
      `CHK("glyph", tcd_pkg::CH_ERROR, lastChar)
      `CHK("set", tcd_pkg::CS_SOFT2, activeCharset)
      $display("t_charset done");
   endtask
   task automatic t_flow;
      kbdValid <= 1'b1;
      push("\023");
      `CHK("suspend", 1'b1, txSuspended)
      `CHK("txValid", 1'b0, txValid)
      push("\021");
      `CHK("suspend", 1'b0, txSuspended)
      $display("t_flow done");
   endtask
   task reportAndStop;
      $display("checks %0d mismatches %0d", checkCount, nMismatch);
      if (nMismatch == 0 && checkCount > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence and watchdog
   initial
   begin
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      t_cursor();
      t_charset();
      t_flow();
      reportAndStop();
   end
   initial
   begin
      #200000;
      nMismatch++;
      reportAndStop();
   end
endmodule // tcd_decoder_tb

// >>> verif/tcd_host_sink.sv
// Purpose: Display and transmit sinks on the far side
// Assumes: Fixed stall pattern
// Notes:   Keeps the last shown glyph
module tcd_host_sink (
   input wire logic       clk_sys,
   input wire logic       nrst,
   input wire logic [7:0] dispChar,
   input wire logic       dispValid,
   output logic           dispReady,
   output logic           txReady,
   output logic [7:0]     lastChar
);
   logic [2:0] cnt;
   // Stall counter and glyph capture
   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt      <= 3'h0;
         lastChar <= 8'h00;
      end
      else
      begin
         cnt <= cnt + 3'h1;
         if (dispValid && dispReady) lastChar <= dispChar;
      end
   end
   assign dispReady = (cnt != 3'h7);
   assign txReady = cnt[0];
endmodule // tcd_host_sink
